/* eic_core.v */
`timescale 1ns/10ps
`include "eic_defs.vh"
// How it works
// - Two levels, two save pairs, two returns.
// - Save state and address, load state, jump.
// - Interrupt forces privileged real mode.
// - Older retire, younger discarded on interrupt.
// - Return restores matching pair, synchronizes context.
// - Masked classes not taken while disabled.
// - Classify causes as synchronous or asynchronous.
// - Return address: fault, next, or boundary.
// - No younger instruction runs before handler.
// - Older complete; bus stores may linger.
// - Machine check alone is imprecise.
// - Imprecise point follows recognition boundary.
// - Multi/string load may leave registers written.
// - Multi/string store may leave bytes written.
// - Crossing load never writes a register.
// - Crossing store keeps base register unchanged.
// - No forbidden write; others leave no state.
// - Interrupted aligned access issues no request.
// - Issued aligned access is never interrupted.
// - Critical uses critical pair, noncritical other.
// - Handler equals vector prefix plus offset.
module eic_core (
    // Clock and reset.
    input  wire        clock_i,
    input  wire        nrst_i,
    // External interrupt pins, asynchronous to the core.
    input  wire        crit_pin_i,
    input  wire        ext_pin_i,
    input  wire        bus_err_pin_i,
    // Internal asynchronous sources.
    input  wire        wdog_i,
    input  wire        pit_i,
    input  wire        fit_i,
    input  wire        debug_i,
    // Synchronous causes raised by the instruction at the boundary.
    input  wire        dstore_i,
    input  wire        istore_i,
    input  wire        align_i,
    input  wire        prog_i,
    input  wire        syscall_i,
    input  wire        dtlb_i,
    input  wire        itlb_i,
    input  wire        sync_next_i,
    // Pipeline boundary.
    input  wire        boundary_i,
    input  wire        older_done_i,
    input  wire [31:0] cur_addr_i,
    input  wire [31:0] next_addr_i,
    // Pending memory access of the instruction at the boundary.
    input  wire        mem_pend_i,
    input  wire        mem_aligned_i,
    input  wire        mem_cross_i,
    input  wire        mem_load_i,
    input  wire        mem_update_i,
    input  wire        mem_prot_ok_i,
    // Returns from interrupt.
    input  wire        rfi_i,
    input  wire        rfci_i,
    // Software writes of the special registers.
    input  wire [31:0] spr_data_i,
    input  wire        wr_msw_i,
    input  wire        wr_vbp_i,
    input  wire        wr_nc_addr_i,
    input  wire        wr_nc_state_i,
    input  wire        wr_cr_addr_i,
    input  wire        wr_cr_state_i,
    // Control of the pipeline and fetch.
    output reg         redirect_o,
    output reg  [31:0] redirect_addr_o,
    output reg         flush_o,
    output reg         context_sync_o,
    output reg         stall_o,
    // Access control of the instruction at the boundary.
    output reg         bus_req_ok_o,
    output reg         reg_wr_ok_o,
    output reg         base_upd_ok_o,
    output reg         mem_wr_ok_o,
    // Status of the last interrupt.
    output reg  [3:0]  cause_o,
    output reg         cause_sync_o,
    output reg         cause_imprecise_o,
    output reg         taken_crit_o,
    // Architectural registers.
    output reg  [31:0] machine_state_word_o,
    output reg  [15:0] vector_base_prefix_o,
    output wire [31:0] noncritical_return_addr_save_o,
    output wire [31:0] noncritical_state_save_o,
    output wire [31:0] critical_return_addr_save_o,
    output wire [31:0] critical_state_save_o
);

    // Two-stage synchronisers for the external pins.
    reg  [2:0]  pin_meta;
    reg  [2:0]  pin_sync;
    // Machine check latched from recognition until it is taken.
    reg         mcheck_pend;
    // Core access request already presented on the local bus.
    reg         bus_issued;
    // Pending cause vector and chosen cause.
    reg  [13:0] pend;
    reg  [3:0]  sel;
    reg         sel_valid;
    wire        sel_crit;
    wire        take;
    // Saved values for the interrupt in flight.
    wire [31:0] save_addr;
    wire [31:0] new_msw;
    wire        take_nc;
    wire        take_cr;

    // Pins pass two flip-flops before any logic reads them.
    // Only the second stage feeds logic; the first may still be settling.
    always @(posedge clock_i) begin
        if (!nrst_i) begin
            pin_meta <= 3'h0;
            pin_sync <= 3'h0;
        end else begin
            pin_meta <= {bus_err_pin_i, ext_pin_i, crit_pin_i};
            pin_sync <= pin_meta;
        end
    end

    // Returns the vector offset of a cause.
    function [15:0] eic_vector;
        input [3:0] c;
        begin
            case (c)
                `EIC_C_CRIT_IN: eic_vector = `EIC_V_CRIT_IN;
                `EIC_C_MCHECK:  eic_vector = `EIC_V_MCHECK;
                `EIC_C_WDOG:    eic_vector = `EIC_V_WDOG;
                `EIC_C_DEBUG:   eic_vector = `EIC_V_DEBUG;
                `EIC_C_DSTORE:  eic_vector = `EIC_V_DSTORE;
                `EIC_C_ISTORE:  eic_vector = `EIC_V_ISTORE;
                `EIC_C_EXT:     eic_vector = `EIC_V_EXT;
                `EIC_C_ALIGN:   eic_vector = `EIC_V_ALIGN;
                `EIC_C_PROG:    eic_vector = `EIC_V_PROG;
                `EIC_C_SYSCALL: eic_vector = `EIC_V_SYSCALL;
                `EIC_C_PIT:     eic_vector = `EIC_V_PIT;
                `EIC_C_FIT:     eic_vector = `EIC_V_FIT;
                `EIC_C_DTLB:    eic_vector = `EIC_V_DTLB;
                `EIC_C_ITLB:    eic_vector = `EIC_V_ITLB;
                default:        eic_vector = `EIC_V_PROG;
            endcase
        end
    endfunction

    // Tells whether a cause arises from instruction execution.
    function eic_is_sync;
        input [3:0] c;
        begin
            eic_is_sync = (c >= `EIC_C_DSTORE) && (c != `EIC_C_EXT)
                          && (c != `EIC_C_PIT) && (c != `EIC_C_FIT);
        end
    endfunction

    // Machine check is recognized at once and held until taken, so the
    // interrupt may land several instructions after its cause.
    // A new bus error in the cycle of the take wins over the clear, so it
    // is not lost.
    always @(posedge clock_i) begin
        if (!nrst_i) begin
            mcheck_pend <= 1'b0;
        end else if (pin_sync[2]) begin
            mcheck_pend <= 1'b1;
        end else if (take && sel == `EIC_C_MCHECK) begin
            mcheck_pend <= 1'b0;
        end
    end

    // Tracks an aligned access whose bus request is already out.
    // While it is set no interrupt is taken; it drops at the boundary.
    always @(posedge clock_i) begin
        if (!nrst_i) begin
            bus_issued <= 1'b0;
        end else if (!mem_pend_i || boundary_i) begin
            bus_issued <= 1'b0;
        end else if (mem_aligned_i && !mem_cross_i && !take) begin
            bus_issued <= 1'b1;
        end
    end

    // Gathers pending causes, gating maskable ones by the state word.
    // Debug and the synchronous causes have no enable bit.
    always @* begin
        pend = 14'h0000;
        pend[`EIC_C_CRIT_IN] = pin_sync[0] & machine_state_word_o[`EIC_MSW_CE];
        pend[`EIC_C_MCHECK]  = mcheck_pend & machine_state_word_o[`EIC_MSW_ME];
        pend[`EIC_C_WDOG]    = wdog_i & machine_state_word_o[`EIC_MSW_CE];
        pend[`EIC_C_DEBUG]   = debug_i;
        pend[`EIC_C_DSTORE]  = dstore_i;
        pend[`EIC_C_ISTORE]  = istore_i;
        pend[`EIC_C_EXT]     = pin_sync[1] & machine_state_word_o[`EIC_MSW_EE];
        pend[`EIC_C_ALIGN]   = align_i;
        pend[`EIC_C_PROG]    = prog_i;
        pend[`EIC_C_SYSCALL] = syscall_i;
        pend[`EIC_C_PIT]     = pit_i & machine_state_word_o[`EIC_MSW_EE];
        pend[`EIC_C_FIT]     = fit_i & machine_state_word_o[`EIC_MSW_EE];
        pend[`EIC_C_DTLB]    = dtlb_i;
        pend[`EIC_C_ITLB]    = itlb_i;
    end

    // Picks the lowest-index pending cause; critical causes sit lowest.
    // The loop counts down so that the lowest pending index writes last.
    integer k;
    always @* begin
        sel = 4'h0;
        sel_valid = 1'b0;
        for (k = `EIC_NCAUSE - 1; k >= 0; k = k - 1) begin
            if (pend[k]) begin
                sel = k[3:0];
                sel_valid = 1'b1;
            end
        end
    end

    assign sel_crit = (sel <= `EIC_C_DEBUG);
    // Taken only at a boundary with all older instructions retired and no
    // issued aligned access in flight.
    assign take = sel_valid && boundary_i && older_done_i && !bus_issued;
    // Each level loads only its own pair, so a critical interrupt may nest
    // inside a noncritical handler without losing the first save.
    assign take_nc = take && !sel_crit;
    assign take_cr = take && sel_crit;
    // Synchronous causes that retire report the next address.
    // Asynchronous causes always report the boundary address.
    assign save_addr = (eic_is_sync(sel) && sync_next_i) ? next_addr_i : cur_addr_i;
    // New state clears relocation, problem state and the level's enables.
    assign new_msw = machine_state_word_o
                     & ~(sel_crit ? `EIC_MSW_CRIT_CLR : `EIC_MSW_NCRIT_CLR);

    // Noncritical pair.
    eic_save_pair u_nc_pair (
        .clock_i      (clock_i),
        .nrst_i       (nrst_i),
        .save_i       (take_nc),
        .save_addr_i  (save_addr),
        .save_state_i (machine_state_word_o),
        .wr_addr_i    (wr_nc_addr_i),
        .wr_state_i   (wr_nc_state_i),
        .wr_data_i    (spr_data_i),
        .addr_o       (noncritical_return_addr_save_o),
        .state_o      (noncritical_state_save_o)
    );

    // Critical pair.
    eic_save_pair u_cr_pair (
        .clock_i      (clock_i),
        .nrst_i       (nrst_i),
        .save_i       (take_cr),
        .save_addr_i  (save_addr),
        .save_state_i (machine_state_word_o),
        .wr_addr_i    (wr_cr_addr_i),
        .wr_state_i   (wr_cr_state_i),
        .wr_data_i    (spr_data_i),
        .addr_o       (critical_return_addr_save_o),
        .state_o      (critical_state_save_o)
    );

    // Machine state word and vector prefix; interrupt beats return beats write.
    always @(posedge clock_i) begin
        if (!nrst_i) begin
            machine_state_word_o <= `EIC_MSW_RESET;
            vector_base_prefix_o <= `EIC_VBP_RESET;
        end else begin
            if (take) begin
                machine_state_word_o <= new_msw;
            end else if (rfci_i) begin
                machine_state_word_o <= critical_state_save_o;
            end else if (rfi_i) begin
                machine_state_word_o <= noncritical_state_save_o;
            end else if (wr_msw_i) begin
                machine_state_word_o <= spr_data_i;
            end
            // Only the upper half is kept; the vector offset fills the rest.
            if (wr_vbp_i) begin
                vector_base_prefix_o <= spr_data_i[31:16];
            end
        end
    end

    // Redirect, flush and context sync on interrupt or return.
    // All three pulse for one cycle; the cause fields hold until the next take.
    always @(posedge clock_i) begin
        if (!nrst_i) begin
            redirect_o        <= 1'b0;
            redirect_addr_o   <= 32'h00000000;
            flush_o           <= 1'b0;
            context_sync_o    <= 1'b0;
            cause_o           <= 4'h0;
            cause_sync_o      <= 1'b0;
            cause_imprecise_o <= 1'b0;
            taken_crit_o      <= 1'b0;
        end else begin
            redirect_o     <= take | rfi_i | rfci_i;
            flush_o        <= take | rfi_i | rfci_i;
            context_sync_o <= take | rfi_i | rfci_i;
            if (take) begin
                redirect_addr_o   <= {vector_base_prefix_o, eic_vector(sel)};
                cause_o           <= sel;
                cause_sync_o      <= eic_is_sync(sel);
                cause_imprecise_o <= (sel == `EIC_C_MCHECK);
                taken_crit_o      <= sel_crit;
            end else if (rfci_i) begin
                redirect_addr_o <= critical_return_addr_save_o;
            end else if (rfi_i) begin
                redirect_addr_o <= noncritical_return_addr_save_o;
            end
        end
    end

    // Access permissions for the instruction at the boundary. Older
    // bus stores are not held back by an interrupt.
    // Like every output here they lag the deciding edge by one cycle.
    always @(posedge clock_i) begin
        if (!nrst_i) begin
            stall_o       <= 1'b0;
            bus_req_ok_o  <= 1'b0;
            reg_wr_ok_o   <= 1'b0;
            base_upd_ok_o <= 1'b0;
            mem_wr_ok_o   <= 1'b0;
        end else begin
            // Holds issue while older work drains before an interrupt.
            stall_o <= sel_valid && !(boundary_i && older_done_i);
            // An aligned access that is interrupted never reaches the bus.
            bus_req_ok_o <= mem_pend_i && !(take && mem_aligned_i && !mem_cross_i);
            // Crossing loads and update stores keep registers clean on take;
            // multi and string loads may keep partial writes.
            reg_wr_ok_o <= mem_load_i && !(take && mem_cross_i);
            base_upd_ok_o <= mem_update_i && !take;
            // Stores may leave partial bytes, never in protected storage.
            mem_wr_ok_o <= mem_pend_i && !mem_load_i && mem_prot_ok_i;
        end
    end

    // Software that keeps operands aligned or guarded never sees a restart;
    // nothing in this block enforces that.

endmodule

/* eic_core_asserts.sv */
`timescale 1ns/10ps
`include "eic_defs.vh"
// Watches the exception controller ports for the taking and return rules.
module eic_core_asserts (
    // Clock and reset.
    input wire        clock_i,
    input wire        nrst_i,
    // Inputs that qualify a take or a return.
    input wire        boundary_i,
    input wire        older_done_i,
    input wire        rfi_i,
    input wire        rfci_i,
    input wire        mem_pend_i,
    input wire        mem_aligned_i,
    input wire        mem_cross_i,
    input wire        mem_load_i,
    input wire        mem_update_i,
    input wire        mem_prot_ok_i,
    // Outputs under watch.
    input wire        redirect_o,
    input wire [31:0] redirect_addr_o,
    input wire        context_sync_o,
    input wire        bus_req_ok_o,
    input wire        reg_wr_ok_o,
    input wire        base_upd_ok_o,
    input wire        mem_wr_ok_o,
    input wire [3:0]  cause_o,
    input wire        cause_sync_o,
    input wire        cause_imprecise_o,
    input wire        taken_crit_o,
    input wire [31:0] machine_state_word_o,
    input wire [15:0] vector_base_prefix_o,
    input wire [31:0] noncritical_state_save_o,
    input wire [31:0] critical_state_save_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!nrst_i);
    reg  ret_q; // A return was requested on the previous edge.
    wire tk;    // Redirect caused by taking an interrupt, not by a return.
    // Remembers returns so that their redirects are told apart from takes.
    always @(posedge clock_i) begin
        ret_q <= nrst_i & (rfi_i | rfci_i);
    end
    assign tk = redirect_o & ~ret_q;
    AST_SYNC_CTX: assert property (redirect_o |-> context_sync_o)
        else $error("redirect without context synchronization");
    AST_REAL_MODE: assert property (tk |-> !machine_state_word_o[`EIC_MSW_PR] &&
        !machine_state_word_o[`EIC_MSW_IR] && !machine_state_word_o[`EIC_MSW_DR])
        else $error("interrupt left user or relocated mode");
    AST_VECTOR: assert property (tk |-> redirect_addr_o[31:16] == vector_base_prefix_o)
        else $error("handler address not based on vector prefix");
    AST_PAIR_STATE: assert property (tk |-> (taken_crit_o ? critical_state_save_o :
        noncritical_state_save_o) == $past(machine_state_word_o))
        else $error("wrong pair holds the saved state");
    AST_NC_KEEP: assert property (tk && taken_crit_o |-> $stable(noncritical_state_save_o))
        else $error("critical take disturbed the noncritical pair");
    AST_NEW_MSW: assert property (tk |-> machine_state_word_o == ($past(machine_state_word_o) &
        ~(taken_crit_o ? `EIC_MSW_CRIT_CLR : `EIC_MSW_NCRIT_CLR)))
        else $error("new machine state wrong after take");
    AST_RETURN: assert property ((rfi_i || rfci_i) && !boundary_i |=> redirect_o &&
        machine_state_word_o == $past(rfci_i ? critical_state_save_o : noncritical_state_save_o))
        else $error("return did not restore the machine state");
    AST_MASK: assert property (tk && cause_o == `EIC_C_EXT |->
        $past(machine_state_word_o[`EIC_MSW_EE]))
        else $error("external interrupt taken while disabled");
    AST_IMPRECISE: assert property (tk |-> cause_imprecise_o == (cause_o == `EIC_C_MCHECK))
        else $error("imprecise flag wrong");
    AST_SYNC_CLASS: assert property (tk && cause_o != `EIC_C_DEBUG |-> cause_sync_o ==
        ((cause_o >= 4'h4 && cause_o <= 4'h9 && cause_o != 4'h6) || cause_o >= 4'hc))
        else $error("synchronous class wrong");
    AST_BOUNDARY: assert property (tk |-> $past(boundary_i && older_done_i))
        else $error("take before older instructions completed");
    AST_NO_BUS: assert property (tk && $past(mem_pend_i && mem_aligned_i && !mem_cross_i) |->
        !bus_req_ok_o)
        else $error("interrupted aligned access reached the bus");
    AST_CROSS: assert property (tk && $past(mem_pend_i && mem_cross_i) |->
        !($past(mem_load_i) && reg_wr_ok_o) && !($past(mem_update_i) && base_upd_ok_o))
        else $error("crossing access changed a register");
    AST_PROT: assert property (tk && $past(mem_pend_i && !mem_prot_ok_i) |-> !mem_wr_ok_o)
        else $error("protected location writable after take");
    COV_CRIT: cover property (tk && taken_crit_o);
    COV_NCRIT: cover property (tk && !taken_crit_o);
    COV_RET: cover property (ret_q && redirect_o);
endmodule
bind eic_core eic_core_asserts eic_core_asserts_i (.*);

/* eic_defs.vh */
`ifndef EIC_DEFS_VH
`define EIC_DEFS_VH
// Machine state word bit positions.
`define EIC_MSW_CE      14
`define EIC_MSW_EE      15
`define EIC_MSW_PR      17
`define EIC_MSW_ME      19
`define EIC_MSW_IR      26
`define EIC_MSW_DR      27
// Reset value of the machine state word.
`define EIC_MSW_RESET   32'h00000000
// Mask of bits a critical interrupt clears.
`define EIC_MSW_CRIT_CLR 32'h0c0ac000
// Mask of bits a noncritical interrupt clears.
`define EIC_MSW_NCRIT_CLR 32'h0c028000
// Cause indices.
`define EIC_C_CRIT_IN   4'h0
`define EIC_C_MCHECK    4'h1
`define EIC_C_WDOG      4'h2
`define EIC_C_DEBUG     4'h3
`define EIC_C_DSTORE    4'h4
`define EIC_C_ISTORE    4'h5
`define EIC_C_EXT       4'h6
`define EIC_C_ALIGN     4'h7
`define EIC_C_PROG      4'h8
`define EIC_C_SYSCALL   4'h9
`define EIC_C_PIT       4'ha
`define EIC_C_FIT       4'hb
`define EIC_C_DTLB      4'hc
`define EIC_C_ITLB      4'hd
`define EIC_NCAUSE      14
// Vector offsets.
`define EIC_V_CRIT_IN   16'h0100
`define EIC_V_MCHECK    16'h0200
`define EIC_V_DSTORE    16'h0300
`define EIC_V_ISTORE    16'h0400
`define EIC_V_EXT       16'h0500
`define EIC_V_ALIGN     16'h0600
`define EIC_V_PROG      16'h0700
`define EIC_V_SYSCALL   16'h0c00
`define EIC_V_PIT       16'h1000
`define EIC_V_FIT       16'h1010
`define EIC_V_WDOG      16'h1020
`define EIC_V_DTLB      16'h1100
`define EIC_V_ITLB      16'h1200
`define EIC_V_DEBUG     16'h2000
// Reset value of the vector base prefix.
`define EIC_VBP_RESET   16'h0000
`endif

/* eic_irq_src.sv */
`timescale 1ns/10ps
// External interrupt sources: levels change off the core clock grid.
module eic_irq_src (
    // Requested levels: critical, external, bus error.
    input  wire [2:0] req_i,
    // Pin levels toward the core.
    output reg        crit_pin_o,
    output reg        ext_pin_o,
    output reg        bus_err_pin_o
);
    // The skew keeps the pins asynchronous to the core clock.
    initial {crit_pin_o, ext_pin_o, bus_err_pin_o} = 3'h0;
    always @(req_i) begin
        {crit_pin_o, ext_pin_o, bus_err_pin_o} <= #3 req_i;
    end
endmodule

/* eic_save_pair.v */
`timescale 1ns/10ps
// One save/restore register pair: return address and machine state.
module eic_save_pair (
    // Clock and reset.
    input  wire        clock_i,
    input  wire        nrst_i,
    // Capture and software write.
    input  wire        save_i,
    input  wire [31:0] save_addr_i,
    input  wire [31:0] save_state_i,
    input  wire        wr_addr_i,
    input  wire        wr_state_i,
    input  wire [31:0] wr_data_i,
    // Stored values.
    output reg  [31:0] addr_o,
    output reg  [31:0] state_o
);
    // The pair loads on an interrupt; software may also rewrite it.
    always @(posedge clock_i) begin
        if (!nrst_i) begin
            addr_o  <= 32'h00000000;
            state_o <= 32'h00000000;
        end else if (save_i) begin
            addr_o  <= save_addr_i;
            state_o <= save_state_i;
        end else begin
            if (wr_addr_i) begin
                addr_o <= wr_data_i;
            end
            if (wr_state_i) begin
                state_o <= wr_data_i;
            end
        end
    end
endmodule

/* tb_eic_core.sv */
`timescale 1ns/10ps
`include "eic_defs.vh"
module tb_eic_core;
    typedef struct packed {logic [31:0] a; logic [31:0] m; logic [3:0] c; logic k; logic r;} exp_t;
    localparam [27:0] CT = {`EIC_C_ITLB, `EIC_C_DTLB, `EIC_C_SYSCALL, `EIC_C_PROG,
        `EIC_C_ALIGN, `EIC_C_ISTORE, `EIC_C_DSTORE};
    localparam [111:0] OT = {`EIC_V_ITLB, `EIC_V_DTLB, `EIC_V_SYSCALL, `EIC_V_PROG,
        `EIC_V_ALIGN, `EIC_V_ISTORE, `EIC_V_DSTORE};
    // Stimulus: pins {crit,ext,berr}, async {debug,fit,pit,wdog}, sync and memory groups.
    reg clock_i = 0, nrst_i = 0, bnd = 0, odone = 0, snext = 0, rfi = 0, rfci = 0;
    reg [2:0] pin_req = 0;
    reg [3:0] av = 0;
    reg [6:0] sv = 0;
    reg [5:0] mv = 0, wv = 0;
    reg [31:0] cur = 0, nxt = 0, sdata = 0, msw_m = 0, nsm = 0, nam = 0, csm = 0, cam = 0, seed;
    reg [15:0] vbp_m = 0;
    integer bad_count = 0, total_checks = 0, i;
    exp_t q[$];
    exp_t e;
    wire cp, ep, bp, rd, fl, cs, st, br, rw, bu, mw, csy, cim, kr;
    wire [31:0] ra, msw, na, ns, ca, cst;
    wire [3:0] cz;
    wire [15:0] vbp;
    eic_irq_src eic_irq_src_i (.req_i(pin_req), .crit_pin_o(cp), .ext_pin_o(ep), .bus_err_pin_o(bp));
    eic_core eic_core_i (.clock_i(clock_i), .nrst_i(nrst_i), .crit_pin_i(cp), .ext_pin_i(ep),
        .bus_err_pin_i(bp), .wdog_i(av[0]), .pit_i(av[1]), .fit_i(av[2]), .debug_i(av[3]),
        .dstore_i(sv[0]), .istore_i(sv[1]), .align_i(sv[2]), .prog_i(sv[3]), .syscall_i(sv[4]),
        .dtlb_i(sv[5]), .itlb_i(sv[6]), .sync_next_i(snext), .boundary_i(bnd),
        .older_done_i(odone), .cur_addr_i(cur), .next_addr_i(nxt), .mem_pend_i(mv[0]),
        .mem_aligned_i(mv[1]), .mem_cross_i(mv[2]), .mem_load_i(mv[3]), .mem_update_i(mv[4]),
        .mem_prot_ok_i(mv[5]), .rfi_i(rfi), .rfci_i(rfci), .spr_data_i(sdata), .wr_msw_i(wv[0]),
        .wr_vbp_i(wv[1]), .wr_nc_addr_i(wv[2]), .wr_nc_state_i(wv[3]), .wr_cr_addr_i(wv[4]),
        .wr_cr_state_i(wv[5]), .redirect_o(rd), .redirect_addr_o(ra), .flush_o(fl),
        .context_sync_o(cs), .stall_o(st), .bus_req_ok_o(br), .reg_wr_ok_o(rw),
        .base_upd_ok_o(bu), .mem_wr_ok_o(mw), .cause_o(cz), .cause_sync_o(csy),
        .cause_imprecise_o(cim), .taken_crit_o(kr), .machine_state_word_o(msw),
        .vector_base_prefix_o(vbp), .noncritical_return_addr_save_o(na),
        .noncritical_state_save_o(ns), .critical_return_addr_save_o(ca),
        .critical_state_save_o(cst));
    always #5 clock_i = ~clock_i;
    // Compares one value and counts it.
    task check(input [31:0] seen, input [31:0] exp);
        begin
            total_checks = total_checks + 1;
            if (seen !== exp) begin
                bad_count = bad_count + 1;
                $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    // Prints the verdict and ends the run.
    task results;
        begin
            if (bad_count == 0 && total_checks > 0) $display("Test passed");
            else $display("Test failed");
            $finish;
        end
    endtask
    // Pulses special-register write strobes for one cycle.
    task wr(input [5:0] w, input [31:0] d);
        begin
            sdata = d;
            wv = w;
            @(negedge clock_i);
            wv = 0;
            if (w[0]) msw_m = d;
            if (w[1]) vbp_m = d[31:16];
        end
    endtask
    // Offers one boundary with the given causes and notes the expected take.
    task take(input [6:0] s, input [3:0] a, input [3:0] c, input [15:0] off, input k);
        reg [31:0] rt, old;
        begin
            cur = $urandom;
            nxt = $urandom;
            snext = (a == 0 && s != 0) ? $urandom : 0;
            mv = $urandom;
            sv = s;
            av = a;
            bnd = 1;
            odone = 1;
            rt = snext ? nxt : cur;
            old = msw_m;
            msw_m = msw_m & ~(k ? `EIC_MSW_CRIT_CLR : `EIC_MSW_NCRIT_CLR);
            q.push_back({vbp_m, off, msw_m, c, k, 1'b0});
            @(negedge clock_i);
            // Aligned scalar operands that are interrupted never reach the bus.
            check({br & mv[1] & ~mv[2], mw & ~mv[5]}, 0);
            check({rw, bu} & {2{mv[2]}}, 0);
            {sv, av, bnd, odone, mv, snext} = 0;
            if (k) begin cam = rt; csm = old; end else begin nam = rt; nsm = old; end
            check(k ? ca : na, rt);
            check(k ? cst : ns, old);
            check(k ? ns : cst, k ? nsm : csm);
            @(negedge clock_i);
        end
    endtask
    // Returns from the noncritical or the critical handler.
    task ret(input k);
        begin
            msw_m = k ? csm : nsm;
            q.push_back({k ? cam : nam, msw_m, 4'h0, 1'b0, 1'b1});
            if (k) rfci = 1; else rfi = 1;
            @(negedge clock_i);
            if (k) rfci = 0; else rfi = 0;
        end
    endtask
    // Takes the oldest note whenever the core redirects fetch.
    always @(negedge clock_i) begin
        if (rd === 1'b1) begin
            check({fl, cs}, 2'h3);
            if (q.size() == 0) check(32'h1, 32'h0);
            else begin
                e = q.pop_front();
                check(ra, e.a);
                check(msw, e.m);
                if (!e.r) check({kr, cz}, {e.k, e.c});
            end
        end
    end
    initial begin
        #200000;
        bad_count = bad_count + 1;
        results;
    end
    initial begin
        seed = $urandom(72);
        repeat (5) @(negedge clock_i);
        nrst_i = 1;
        check(msw | na | ns | ca | cst, `EIC_MSW_RESET);
        check(vbp, `EIC_VBP_RESET);
        wr(6'h03, $urandom);
        check(vbp, vbp_m);
        for (i = 0; i < 7; i = i + 1) begin
            take(7'h01 << i, 4'h0, CT[i*4 +: 4], OT[i*16 +: 16], 1'b0);
            ret(1'b0);
        end
        wr(6'h01, $urandom | 32'h0008c000);
        take(0, 4'h2, `EIC_C_PIT, `EIC_V_PIT, 0);
        take(0, 4'h1, `EIC_C_WDOG, `EIC_V_WDOG, 1);
        ret(1);
        ret(0);
        take(0, 4'h4, `EIC_C_FIT, `EIC_V_FIT, 0);
        take(7'h01, 4'h8, `EIC_C_DEBUG, `EIC_V_DEBUG, 1);
        ret(1);
        ret(0);
        wr(6'h01, $urandom & ~32'h00008000);
        pin_req = 3'h2;
        {bnd, odone} = 2'h3;
        repeat (8) @(negedge clock_i);
        {bnd, odone} = 0;
        wr(6'h01, msw_m | 32'h00008000);
        take(0, 0, `EIC_C_EXT, `EIC_V_EXT, 0);
        pin_req = 0;
        repeat (4) @(negedge clock_i);
        ret(0);
        wr(6'h01, msw_m | 32'h00084000);
        pin_req = 3'h4;
        repeat (4) @(negedge clock_i);
        check(st, 1'b1);
        take(0, 0, `EIC_C_CRIT_IN, `EIC_V_CRIT_IN, 1);
        pin_req = 3'h1;
        repeat (4) @(negedge clock_i);
        ret(1);
        take(0, 0, `EIC_C_MCHECK, `EIC_V_MCHECK, 1);
        check(cim, 1'b1);
        pin_req = 0;
        repeat (6) @(negedge clock_i);
        check(q.size(), 0);
        results;
    end
endmodule
